// [rtl/atc_pkg.sv]
/*
  Shared constants and types of the acquisition trigger control block:
  register offsets, command and status bit positions, reset values,
  trigger modes, sequencer states and timing figures.
  Assumes a 10 MHz system clock and a plain one-cycle register port.
*/
`default_nettype none
package atc_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int TO_W = 16;
  localparam int BUF_W = 24;
  localparam int BURST_W = 16;
  localparam int ERR_W = 16;
  localparam int TMR_W = 24;
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CMD = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_TIMEOUT = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_BUFSIZE = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_BURST = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_ERR_COUNT = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_SAMPLES = 8'h24;
  // Command register bits (write-only pulses)
  localparam int CMD_INIT = 0;
  localparam int CMD_ABORT = 1;
  // Status register bits
  localparam int SB_BUFMODE = 0;
  localparam int SB_BIAS = 1;
  localparam int SB_MONDIR = 2;
  localparam int SB_RUN = 16;
  localparam int SB_PAUSE = 17;
  localparam int SB_STOP = 18;
  localparam int SB_GATE = 23;
  // Interrupt bits
  localparam int IRQ_W = 5;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_PAUSE = 1;
  localparam int IRQ_TIMEOUT = 2;
  localparam int IRQ_PROF = 3;
  localparam int IRQ_ERR = 4;
  // Field values
  localparam logic [1:0] MON_DIRECT = 2'h3;
  localparam logic SRC_INT = 1'b0;
  localparam logic SRC_EXT = 1'b1;
  localparam logic [BURST_W-1:0] BURST_STEP = 16'h0001;
  localparam logic [DATA_W-1:0] CTRL_RST = 32'h0000_0000;
  // Timing
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned TIMEOUT_UNIT_S = 1;
  localparam int unsigned SEC_CYCLES_DEF = CLK_HZ * TIMEOUT_UNIT_S;
  localparam int unsigned TOGGLE_WIN_US = 1000;
  localparam int unsigned TOGGLE_CYCLES_DEF = (CLK_HZ / 1_000_000) * TOGGLE_WIN_US;

  typedef enum logic [2:0] {
    MODE_FREE, MODE_SELF, MODE_GSTART, MODE_GHALT, MODE_GSTEP, MODE_GWINDOW
  } atc_mode_t;

  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_MEASURE, ST_PAUSED} atc_state_t;

  typedef struct packed {
    logic [19:0] rsvd;
    logic bias_en;
    logic [2:0] mode;
    logic pause_src;
    logic stop_src;
    logic start_src;
    logic polarity;
    logic profile_en;
    logic loop_en;
    logic [1:0] mon_func;
  } atc_ctrl_t;
endpackage
`default_nettype wire

// [rtl/atc_top.sv]
/*
  Acquisition trigger and control block: trigger mode sequencer, source
  selection, gate polarity, burst and stop counting, regulation loop and
  profile flags, host timeout supervision of the bias supply, error queue
  count, interrupt status and mask, and the register port.
  Assumes all inputs synchronous to clk except the external gate pin, and
  internal trigger, sample and message strobes one cycle long.
*/
// Chosen here: the placing of the registers and strobed register access.
`default_nettype none

module atc_top #(
  parameter int unsigned SEC_CYCLES = atc_pkg::SEC_CYCLES_DEF,
  parameter int unsigned TOGGLE_CYCLES = atc_pkg::TOGGLE_CYCLES_DEF
) (
  input wire logic clk, // System clock, 10 MHz
  input wire logic arst_n, // Asynchronous reset, active low
  input wire logic [atc_pkg::ADDR_W-1:0] addr, // Register byte address
  input wire logic [atc_pkg::DATA_W-1:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  output logic [atc_pkg::DATA_W-1:0] rdata, // Read data, cycle after rd
  input wire logic ext_gate, // External connector trigger pin
  input wire logic int_start, // Internal start trigger pulse
  input wire logic int_stop, // Internal stop trigger pulse
  input wire logic int_pause, // Internal pause trigger pulse
  input wire logic sample_stored, // One sample stored pulse
  input wire logic profile_done, // All profile points gathered pulse
  input wire logic host_msg_valid, // Valid host message pulse
  input wire logic err_push, // Error queue entry added
  input wire logic err_pop, // Error queue entry read
  output logic acq_measuring, // Acquisition running
  output logic acq_paused, // Waiting for a trigger
  output logic acq_stopped, // Acquisition stopped
  output logic buffered_mode, // Buffered acquisition active
  output logic regulation_loop_en, // Regulation loop enable
  output logic profile_active, // Automatic profile running
  output logic monitor_direct, // Monitor outputs direct or loop driven
  output logic bias_supply_en, // Bias supply on
  output logic irq // Level interrupt, unmasked event pending
);

  atc_pkg::atc_ctrl_t ctrl_reg;
  logic [atc_pkg::TO_W-1:0] timeout_reg;
  logic [atc_pkg::BUF_W-1:0] bufsize_reg;
  logic [atc_pkg::BURST_W-1:0] burst_reg;
  logic [atc_pkg::IRQ_W-1:0] irq_stat_reg;
  logic [atc_pkg::IRQ_W-1:0] irq_mask_reg;
  logic [atc_pkg::ERR_W-1:0] err_cnt_reg;
  logic [atc_pkg::BUF_W-1:0] samp_cnt_reg;
  logic [atc_pkg::BURST_W-1:0] burst_cnt_reg;
  logic [atc_pkg::TMR_W-1:0] sec_div_reg;
  logic [atc_pkg::TO_W-1:0] sec_cnt_reg;
  logic [atc_pkg::TMR_W-1:0] toggle_cnt_reg;
  logic [atc_pkg::DATA_W-1:0] rdata_reg;
  logic gate_meta_reg;
  logic gate_sync_reg;
  logic gate_prev_reg;
  logic bias_reg;
  logic profile_reg;
  atc_pkg::atc_state_t state_reg;
  atc_pkg::atc_state_t state_next;

  atc_pkg::atc_mode_t mode;
  logic wr_ctrl;
  atc_pkg::atc_ctrl_t wr_fields;
  atc_pkg::atc_ctrl_t ctrl_view;
  logic wr_cmd;
  logic cmd_init;
  logic cmd_abort;
  logic ext_edge;
  logic ext_any_edge;
  logic start_ev;
  logic stop_ev;
  logic pause_ev;
  logic [atc_pkg::BURST_W-1:0] burst_eff;
  logic samp_last;
  logic burst_last;
  logic sec_tick;
  logic timeout_fire;
  logic [atc_pkg::IRQ_W-1:0] irq_events;
  logic [atc_pkg::DATA_W-1:0] status_word;

  // Write decode; command bits act only in the cycle of the write
  assign wr_ctrl = wr && (addr == atc_pkg::OFS_CTRL);
  assign wr_fields = wdata;
  assign wr_cmd = wr && (addr == atc_pkg::OFS_CMD);
  assign cmd_init = wr_cmd && wdata[atc_pkg::CMD_INIT];
  assign cmd_abort = wr_cmd && wdata[atc_pkg::CMD_ABORT];

  // Illegal mode codes fall back to free-source so the sequencer never hangs
  always_comb begin
    unique case (ctrl_reg.mode)
      3'h0: mode = atc_pkg::MODE_FREE;
      3'h1: mode = atc_pkg::MODE_SELF;
      3'h2: mode = atc_pkg::MODE_GSTART;
      3'h3: mode = atc_pkg::MODE_GHALT;
      3'h4: mode = atc_pkg::MODE_GSTEP;
      3'h5: mode = atc_pkg::MODE_GWINDOW;
      default: mode = atc_pkg::MODE_FREE;
    endcase
  end

  // Control, timeout, buffer and burst settings
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg <= atc_pkg::CTRL_RST;
      timeout_reg <= '0;
      bufsize_reg <= '0;
      burst_reg <= '0;
      irq_mask_reg <= '0;
    end else if (wr) begin
      unique case (addr)
        atc_pkg::OFS_CTRL: ctrl_reg <= wdata;
        atc_pkg::OFS_TIMEOUT: timeout_reg <= wdata[atc_pkg::TO_W-1:0];
        atc_pkg::OFS_BUFSIZE: bufsize_reg <= wdata[atc_pkg::BUF_W-1:0];
        atc_pkg::OFS_BURST: burst_reg <= wdata[atc_pkg::BURST_W-1:0];
        atc_pkg::OFS_IRQ_MASK: irq_mask_reg <= wdata[atc_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // Profile flag; a host write in the completion cycle wins, since it
  // starts or stops a new profile deliberately
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      profile_reg <= 1'b0;
    end else if (wr_ctrl) begin
      profile_reg <= wr_fields.profile_en;
    end else if (profile_done) begin
      profile_reg <= 1'b0;
    end
  end

  // Bias enable; the timeout clears it unless the host rewrites it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bias_reg <= 1'b0;
    end else if (wr_ctrl) begin
      bias_reg <= wr_fields.bias_en;
    end else if (timeout_fire) begin
      bias_reg <= 1'b0;
    end
  end

  // Two-stage synchroniser, then one more stage for edge detection
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gate_meta_reg <= 1'b0;
      gate_sync_reg <= 1'b0;
      gate_prev_reg <= 1'b0;
    end else begin
      gate_meta_reg <= ext_gate;
      gate_sync_reg <= gate_meta_reg;
      gate_prev_reg <= gate_sync_reg;
    end
  end

  // Polarity picks the active edge of the external pin only
  assign ext_edge = ctrl_reg.polarity ? (gate_prev_reg && !gate_sync_reg)
                                      : (gate_sync_reg && !gate_prev_reg);
  assign ext_any_edge = gate_sync_reg ^ gate_prev_reg;

  // Source selection; internal strobes bypass polarity entirely
  always_comb begin
    start_ev = (ctrl_reg.start_src == atc_pkg::SRC_EXT) ? ext_edge : int_start;
    stop_ev = 1'b0;
    pause_ev = 1'b0;
    unique case (mode)
      atc_pkg::MODE_FREE: begin
        stop_ev = (ctrl_reg.stop_src == atc_pkg::SRC_EXT) ? ext_edge : int_stop;
        pause_ev = (ctrl_reg.pause_src == atc_pkg::SRC_EXT) ? ext_edge : int_pause;
      end
      atc_pkg::MODE_SELF: start_ev = int_start;
      atc_pkg::MODE_GHALT: begin
        stop_ev = (ctrl_reg.stop_src == atc_pkg::SRC_EXT) ? ext_edge : int_stop;
      end
      atc_pkg::MODE_GWINDOW: begin
        pause_ev = (ctrl_reg.pause_src == atc_pkg::SRC_EXT) ? ext_edge : int_pause;
      end
      atc_pkg::MODE_GSTART, atc_pkg::MODE_GSTEP: ;
    endcase
  end

  // Burst of zero means no automatic pause, except in gated step mode, which pauses after every sample
  assign burst_eff = (mode == atc_pkg::MODE_GSTEP) ? atc_pkg::BURST_STEP : burst_reg;
  assign buffered_mode = (bufsize_reg != '0);
  assign samp_last = buffered_mode && ((samp_cnt_reg + 1'b1) == bufsize_reg);
  assign burst_last = (burst_eff != '0) && ((burst_cnt_reg + 1'b1) == burst_eff);

  // Sequencer: stop wins over pause, pause over further samples
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      atc_pkg::ST_IDLE: begin
        if (cmd_init) state_next = atc_pkg::ST_ARMED;
      end
      atc_pkg::ST_ARMED: begin
        if (start_ev) state_next = atc_pkg::ST_MEASURE;
      end
      atc_pkg::ST_MEASURE: begin
        if (stop_ev) begin
          state_next = atc_pkg::ST_IDLE;
        end else if (sample_stored && samp_last) begin
          state_next = atc_pkg::ST_IDLE;
        end else if (pause_ev || (sample_stored && burst_last)) begin
          state_next = atc_pkg::ST_PAUSED;
        end
      end
      atc_pkg::ST_PAUSED: begin
        if (stop_ev) begin
          state_next = atc_pkg::ST_IDLE;
        end else if (start_ev) begin
          state_next = atc_pkg::ST_MEASURE;
        end
      end
    endcase
    if (cmd_abort) state_next = atc_pkg::ST_IDLE;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= atc_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Sample and burst counters; burst restarts on every resume
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      samp_cnt_reg <= '0;
      burst_cnt_reg <= '0;
    end else if (state_reg == atc_pkg::ST_IDLE && cmd_init) begin
      samp_cnt_reg <= '0;
      burst_cnt_reg <= '0;
    end else if (state_reg == atc_pkg::ST_MEASURE && sample_stored) begin
      samp_cnt_reg <= samp_cnt_reg + 1'b1;
      burst_cnt_reg <= burst_last ? '0 : burst_cnt_reg + 1'b1;
    end else if (state_reg == atc_pkg::ST_PAUSED && state_next == atc_pkg::ST_MEASURE) begin
      burst_cnt_reg <= '0;
    end
  end

  // Seconds divider and timeout counter; a zero setting holds both idle
  localparam logic [atc_pkg::TMR_W-1:0] TMR_W_SEC_LAST = atc_pkg::TMR_W'(SEC_CYCLES - 1);
  assign sec_tick = (sec_div_reg == TMR_W_SEC_LAST);
  assign timeout_fire = (timeout_reg != '0) && sec_tick && ((sec_cnt_reg + 1'b1) >= timeout_reg);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sec_div_reg <= '0;
      sec_cnt_reg <= '0;
    end else if (timeout_reg == '0 || host_msg_valid || timeout_fire) begin
      sec_div_reg <= '0;
      sec_cnt_reg <= '0;
    end else if (sec_tick) begin
      sec_div_reg <= '0;
      sec_cnt_reg <= sec_cnt_reg + 1'b1;
    end else begin
      sec_div_reg <= sec_div_reg + 1'b1;
    end
  end

  // Gate toggling holds for a window after any pin transition
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      toggle_cnt_reg <= '0;
    end else if (ext_any_edge) begin
      toggle_cnt_reg <= atc_pkg::TMR_W'(TOGGLE_CYCLES);
    end else if (toggle_cnt_reg != '0) begin
      toggle_cnt_reg <= toggle_cnt_reg - 1'b1;
    end
  end

  // Error queue count; saturates so a burst of errors cannot wrap to zero
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      err_cnt_reg <= '0;
    end else if (err_push && !err_pop && err_cnt_reg != '1) begin
      err_cnt_reg <= err_cnt_reg + 1'b1;
    end else if (err_pop && !err_push && err_cnt_reg != '0) begin
      err_cnt_reg <= err_cnt_reg - 1'b1;
    end
  end

  // Interrupt events
  always_comb begin
    irq_events = '0;
    irq_events[atc_pkg::IRQ_DONE] = (state_reg != atc_pkg::ST_IDLE)
                                    && (state_next == atc_pkg::ST_IDLE);
    irq_events[atc_pkg::IRQ_PAUSE] = (state_reg == atc_pkg::ST_MEASURE)
                                     && (state_next == atc_pkg::ST_PAUSED);
    irq_events[atc_pkg::IRQ_TIMEOUT] = timeout_fire;
    irq_events[atc_pkg::IRQ_PROF] = profile_done && profile_reg;
    irq_events[atc_pkg::IRQ_ERR] = err_push;
  end

  // Sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_stat_reg <= '0;
    end else begin
      if (wr && addr == atc_pkg::OFS_IRQ_STAT) begin
        irq_stat_reg <= (irq_stat_reg & ~wdata[atc_pkg::IRQ_W-1:0]) | irq_events;
      end else begin
        irq_stat_reg <= irq_stat_reg | irq_events;
      end
    end
  end

  // Status word
  always_comb begin
    status_word = '0;
    status_word[atc_pkg::SB_BUFMODE] = buffered_mode;
    status_word[atc_pkg::SB_BIAS] = bias_reg;
    status_word[atc_pkg::SB_MONDIR] = monitor_direct;
    status_word[atc_pkg::SB_RUN] = (state_reg == atc_pkg::ST_MEASURE);
    status_word[atc_pkg::SB_PAUSE] = (state_reg == atc_pkg::ST_ARMED)
                                     || (state_reg == atc_pkg::ST_PAUSED);
    status_word[atc_pkg::SB_STOP] = (state_reg == atc_pkg::ST_IDLE);
    status_word[atc_pkg::SB_GATE] = (toggle_cnt_reg != '0);
  end

  // Control readback shows live flags
  always_comb begin
    ctrl_view = ctrl_reg;
    ctrl_view.profile_en = profile_reg;
    ctrl_view.bias_en = bias_reg;
  end

  // Read data registered; unmapped and write-only offsets read zero
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_reg <= '0;
    end else if (rd) begin
      unique case (addr)
        atc_pkg::OFS_CTRL: rdata_reg <= ctrl_view;
        atc_pkg::OFS_TIMEOUT: rdata_reg <= {{(atc_pkg::DATA_W-atc_pkg::TO_W){1'b0}}, timeout_reg};
        atc_pkg::OFS_BUFSIZE: rdata_reg <= {{(atc_pkg::DATA_W-atc_pkg::BUF_W){1'b0}}, bufsize_reg};
        atc_pkg::OFS_BURST: rdata_reg <= {{(atc_pkg::DATA_W-atc_pkg::BURST_W){1'b0}}, burst_reg};
        atc_pkg::OFS_STATUS: rdata_reg <= status_word;
        atc_pkg::OFS_IRQ_STAT: rdata_reg <= {{(atc_pkg::DATA_W-atc_pkg::IRQ_W){1'b0}}, irq_stat_reg};
        atc_pkg::OFS_IRQ_MASK: rdata_reg <= {{(atc_pkg::DATA_W-atc_pkg::IRQ_W){1'b0}}, irq_mask_reg};
        atc_pkg::OFS_ERR_COUNT: rdata_reg <= {{(atc_pkg::DATA_W-atc_pkg::ERR_W){1'b0}}, err_cnt_reg};
        atc_pkg::OFS_SAMPLES: rdata_reg <= {{(atc_pkg::DATA_W-atc_pkg::BUF_W){1'b0}}, samp_cnt_reg};
        default: rdata_reg <= '0;
      endcase
    end else begin
      rdata_reg <= '0;
    end
  end

  // Outputs
  assign rdata = rdata_reg;
  assign acq_measuring = status_word[atc_pkg::SB_RUN];
  assign acq_paused = status_word[atc_pkg::SB_PAUSE];
  assign acq_stopped = status_word[atc_pkg::SB_STOP];
  assign regulation_loop_en = ctrl_reg.loop_en;
  assign profile_active = profile_reg;
  assign monitor_direct = (ctrl_reg.mon_func == atc_pkg::MON_DIRECT);
  assign bias_supply_en = bias_reg;
  assign irq = |(irq_stat_reg & irq_mask_reg);

endmodule
`default_nettype wire

// [verification/atc_chk_checker.sv]
/*
  Port-level checker for atc_top: control fields, sequencer states and
  bias supervision. Assumes it is bound to atc_top and sees only its ports.
*/
`default_nettype none
module atc_chk #(
  parameter int unsigned SEC_CYCLES = atc_pkg::SEC_CYCLES_DEF,
  parameter int unsigned TOGGLE_CYCLES = atc_pkg::TOGGLE_CYCLES_DEF
) (
  input wire logic clk, // System clock
  input wire logic arst_n, // Reset, active low
  input wire logic [atc_pkg::ADDR_W-1:0] addr, // Register address
  input wire logic [atc_pkg::DATA_W-1:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic int_start, // Internal start
  input wire logic int_stop, // Internal stop
  input wire logic int_pause, // Internal pause
  input wire logic sample_stored, // Sample pulse
  input wire logic profile_done, // Profile complete
  input wire logic acq_measuring, // Measuring
  input wire logic acq_paused, // Paused or armed
  input wire logic acq_stopped, // Stopped
  input wire logic buffered_mode, // Buffered mode
  input wire logic regulation_loop_en, // Loop enable
  input wire logic profile_active, // Profile flag
  input wire logic monitor_direct, // Monitor direct
  input wire logic bias_supply_en // Bias on
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] ctrl_q;
  logic [15:0] to_q;
  logic ctrl_wr;
  logic [2:0] md;
  assign ctrl_wr = wr && addr == atc_pkg::OFS_CTRL;
  assign md = ctrl_q[10:8];
  // Shadows of host writes, so mode-dependent checks know the setting
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= 32'h0;
      to_q <= 16'h0;
    end else begin
      if (ctrl_wr) begin
        ctrl_q <= wdata;
      end
      if (wr && addr == atc_pkg::OFS_TIMEOUT) begin
        to_q <= wdata[15:0];
      end
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  AST_MON_DIRECT: assert property (
    ctrl_wr |=> monitor_direct == ($past(wdata[1:0]) == atc_pkg::MON_DIRECT))
    else $error("monitor direct flag wrong after control write");
  AST_LOOP_EN: assert property (
    ctrl_wr |=> regulation_loop_en == $past(wdata[2]))
    else $error("loop enable does not follow control write");
  AST_PROF_DONE: assert property (
    profile_active && profile_done && !ctrl_wr |=> !profile_active)
    else $error("profile flag not cleared on completion");
  AST_TO_OFF: assert property (
    bias_supply_en && to_q == 16'h0 && !ctrl_wr |=> bias_supply_en)
    else $error("bias dropped with supervision disabled");
  AST_BUFMODE: assert property (
    wr && addr == atc_pkg::OFS_BUFSIZE |=> buffered_mode == ($past(wdata[23:0]) != 24'h0))
    else $error("buffered mode does not follow buffer size");
  AST_SELF_START: assert property (
    acq_paused && int_start && md == 3'h1 && !wr |=> acq_measuring)
    else $error("self-timed start not taken");
  AST_STOP_IGNORED: assert property (
    acq_measuring && int_stop && md inside {3'h1, 3'h2, 3'h4, 3'h5} && !sample_stored && !wr
    |=> !acq_stopped)
    else $error("stop acted in a mode without stop source");
  AST_PAUSE_IGNORED: assert property (
    acq_measuring && int_pause && md inside {3'h1, 3'h2, 3'h3, 3'h4} && !sample_stored
    && !int_stop && !ctrl_q[6] && !wr |=> acq_measuring)
    else $error("pause acted in a mode without pause source");
  AST_ARM_FIRST: assert property (
    acq_stopped |=> !acq_measuring)
    else $error("measuring began without arming");
  AST_ONE_STATE: assert property (
    $onehot({acq_measuring, acq_paused, acq_stopped}))
    else $error("acquisition state flags not exclusive");
endmodule
bind atc_top atc_chk #(.SEC_CYCLES(SEC_CYCLES), .TOGGLE_CYCLES(TOGGLE_CYCLES)) u_chk (
  .clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr),
  .int_start(int_start), .int_stop(int_stop), .int_pause(int_pause),
  .sample_stored(sample_stored), .profile_done(profile_done),
  .acq_measuring(acq_measuring), .acq_paused(acq_paused), .acq_stopped(acq_stopped),
  .buffered_mode(buffered_mode), .regulation_loop_en(regulation_loop_en),
  .profile_active(profile_active), .monitor_direct(monitor_direct),
  .bias_supply_en(bias_supply_en)
);
`default_nettype wire

// [verification/atc_host.sv]
/*
  Host model: sends valid message pulses at a set spacing.
  Assumes the bench sets the spacing; zero keeps the host silent.
*/
`default_nettype none
module atc_host (
  input wire logic clk, // System clock
  input wire logic arst_n, // Reset, active low
  input wire logic [7:0] period, // Cycles between messages, 0 silent
  output logic host_msg_valid // One-cycle message pulse
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt_reg;
  // Silence is what lets the device timeout run out
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= 8'h00;
      host_msg_valid <= 1'h0;
    end else if (period == 8'h00) begin
      cnt_reg <= 8'h00;
      host_msg_valid <= 1'h0;
    end else begin
      cnt_reg <= (cnt_reg + 8'h01 >= period) ? 8'h00 : cnt_reg + 8'h01;
      host_msg_valid <= (cnt_reg == 8'h00);
    end
  end
endmodule
`default_nettype wire

// [verification/acquisition_trigger_control_tb.sv]
/*
  Self-checking bench for atc_top: registers, modes, bursts, stop count,
  interrupts, gate, timeout, errors.
  Assumes the atc_host model and the bound checker.
*/
`default_nettype none
module acquisition_trigger_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, arst_n, wr, rd, ext_gate, msg_valid;
  logic [7:0] addr, msg_period;
  logic [31:0] wdata, rdata, d;
  logic [6:0] ev;
  logic meas, paus, stopd, bufm, loopen, prof, mondir, bias, irq;
  int n_fail, compares;
  initial clk = 1'h0;
  always #50 clk = ~clk;
  atc_top #(.SEC_CYCLES(10), .TOGGLE_CYCLES(8)) DUT (
    .clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .ext_gate(ext_gate), .int_start(ev[0]), .int_stop(ev[1]),
    .int_pause(ev[2]), .sample_stored(ev[3]), .profile_done(ev[4]),
    .host_msg_valid(msg_valid), .err_push(ev[5]), .err_pop(ev[6]),
    .acq_measuring(meas), .acq_paused(paus), .acq_stopped(stopd), .buffered_mode(bufm),
    .regulation_loop_en(loopen), .profile_active(prof), .monitor_direct(mondir),
    .bias_supply_en(bias), .irq(irq));
  atc_host u_host (.clk(clk), .arst_n(arst_n), .period(msg_period),
    .host_msg_valid(msg_valid));
  function automatic logic [31:0] cw(input logic b, input logic [2:0] m, input logic [7:0] lo);
    return {20'h00000, b, m, lo};
  endfunction
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
    #1;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    #1;
    v = rdata;
  endtask
  // One-cycle pulse on one event input
  task automatic strb(input int k);
    @(posedge clk);
    ev[k] <= 1'h1;
    @(posedge clk);
    ev <= 7'h00;
    #1;
  endtask
  task automatic t_reset;
    logic [7:0] a[4] = '{8'h00, 8'h04, 8'h14, 8'h30};
    logic [31:0] e[4] = '{32'h0, 32'h0, 32'h0004_0000, 32'h0};
    for (int i = 0; i < 4; i++) begin
      rd_reg(a[i], d);
      chk("reset read", d, e[i]);
    end
    $display("test reset done");
  endtask
  task automatic t_ctrl;
    wr_reg(atc_pkg::OFS_CTRL, cw(0, 0, 8'h07));
    chk("loop_en", loopen, 1);
    chk("monitor_direct", mondir, 1);
    rd_reg(atc_pkg::OFS_CTRL, d);
    chk("ctrl readback", d, 32'h7);
    wr_reg(atc_pkg::OFS_CTRL, cw(0, 0, 8'h08));
    tick(5);
    chk("profile held", {loopen, mondir, prof}, 1);
    strb(4);
    chk("profile done", prof, 0);
    $display("test ctrl done");
  endtask
  // Every mode: which of pause and stop take effect
  task automatic t_modes;
    for (int m = 0; m < 6; m++) begin
      wr_reg(atc_pkg::OFS_CTRL, cw(0, m[2:0], 8'h00));
      wr_reg(atc_pkg::OFS_CMD, 32'h1);
      tick(3);
      chk("armed waits", {meas, paus}, 1);
      strb(0);
      chk("started", meas, 1);
      strb(2);
      chk("pause", paus, 32'(m == 0 || m == 5));
      if (paus === 1'h1) strb(0);
      strb(1);
      chk("stop", stopd, 32'(m == 0 || m == 3));
      wr_reg(atc_pkg::OFS_CMD, 32'h2);
    end
    $display("test modes done");
  endtask
  task automatic t_burst;
    wr_reg(atc_pkg::OFS_BURST, 32'h2);
    for (int m = 0; m < 5; m += 4) begin
      wr_reg(atc_pkg::OFS_CTRL, cw(0, m[2:0], 8'h00));
      wr_reg(atc_pkg::OFS_CMD, 32'h1);
      strb(0);
      strb(3);
      chk("burst one", paus, 32'(m == 4));
      if (m == 0) strb(3);
      chk("burst end", paus, 1);
      wr_reg(atc_pkg::OFS_CMD, 32'h2);
    end
    wr_reg(atc_pkg::OFS_BURST, 32'h0);
    $display("test burst done");
  endtask
  task automatic t_buffer;
    wr_reg(atc_pkg::OFS_IRQ_STAT, 32'h1F);
    wr_reg(atc_pkg::OFS_IRQ_MASK, 32'h1);
    wr_reg(atc_pkg::OFS_BUFSIZE, 32'h2);
    chk("buffered on", bufm, 1);
    wr_reg(atc_pkg::OFS_CTRL, cw(0, 1, 8'h00));
    wr_reg(atc_pkg::OFS_CMD, 32'h1);
    strb(0);
    strb(3);
    chk("one sample", meas, 1);
    strb(3);
    chk("stop count", {stopd, irq}, 3);
    rd_reg(atc_pkg::OFS_IRQ_STAT, d);
    chk("done status", d[0], 1);
    wr_reg(atc_pkg::OFS_IRQ_MASK, 32'h0);
    chk("masked", irq, 0);
    wr_reg(atc_pkg::OFS_IRQ_MASK, 32'h1);
    chk("unmasked", irq, 1);
    wr_reg(atc_pkg::OFS_IRQ_STAT, 32'h1);
    chk("cleared", irq, 0);
    wr_reg(atc_pkg::OFS_BUFSIZE, 32'h0);
    chk("buffered off", bufm, 0);
    $display("test buffer done");
  endtask
  task automatic t_ext;
    for (int p = 0; p < 2; p++) begin
      wr_reg(atc_pkg::OFS_CTRL, cw(0, 2, p ? 8'h30 : 8'h20));
      wr_reg(atc_pkg::OFS_CMD, 32'h1);
      @(posedge clk) ext_gate <= 1'h1;
      tick(6);
      chk("rising gate", meas, 32'(p == 0));
      @(posedge clk) ext_gate <= 1'h0;
      tick(6);
      chk("falling gate", meas, 1);
      rd_reg(atc_pkg::OFS_STATUS, d);
      chk("gate toggling", d[23], 1);
      wr_reg(atc_pkg::OFS_CMD, 32'h2);
    end
    wr_reg(atc_pkg::OFS_CTRL, cw(0, 2, 8'h10));
    wr_reg(atc_pkg::OFS_CMD, 32'h1);
    strb(0);
    chk("internal start", meas, 1);
    rd_reg(atc_pkg::OFS_STATUS, d);
    chk("gate quiet", {d[23], d[16]}, 1);
    wr_reg(atc_pkg::OFS_CMD, 32'h2);
    $display("test gate done");
  endtask
  task automatic t_timeout;
    int i;
    msg_period <= 8'h14;
    wr_reg(atc_pkg::OFS_CTRL, cw(1, 0, 8'h00));
    wr_reg(atc_pkg::OFS_TIMEOUT, 32'h3);
    rd_reg(atc_pkg::OFS_TIMEOUT, d);
    chk("timeout read", d, 3);
    tick(120);
    chk("bias kept", bias, 1);
    msg_period <= 8'h00;
    tick(8);
    chk("bias early", bias, 1);
    for (i = 0; i < 60 && bias !== 1'h0; i++) tick(1);
    chk("bias off", bias, 0);
    wr_reg(atc_pkg::OFS_TIMEOUT, 32'h0);
    wr_reg(atc_pkg::OFS_CTRL, cw(1, 0, 8'h00));
    tick(100);
    chk("disabled", bias, 1);
    $display("test timeout done");
  endtask
  task automatic t_err;
    for (int i = 0; i < 3; i++) strb(5);
    strb(6);
    rd_reg(atc_pkg::OFS_ERR_COUNT, d);
    chk("err count", d, 2);
    $display("test errors done");
  endtask
  initial begin
    arst_n = 1'h0;
    {wr, rd, ext_gate} = 3'h0;
    addr = 8'h00;
    msg_period = 8'h00;
    wdata = 32'h0;
    ev = 7'h00;
    n_fail = 0;
    compares = 0;
    repeat (12) @(posedge clk);
    arst_n <= 1'h1;
    t_reset;
    t_ctrl;
    t_modes;
    t_burst;
    t_buffer;
    t_ext;
    t_timeout;
    t_err;
    close_out;
  end
  // Cuts a hang short
  initial begin
    repeat (50000) @(posedge clk);
    n_fail++;
    close_out;
  end
endmodule
`default_nettype wire
